//--- rtl/pic_top.sv
`timescale 1ns/1ps
module pic_top (
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire logic        ce_i,
   // configuration
   input  wire logic [7:0]  irq_enable_reg_a_i,
   input  wire logic [7:0]  irq_enable_reg_b_i,
   input  wire logic [7:0]  prio_low_reg_a_i,
   input  wire logic [7:0]  prio_high_reg_a_i,
   input  wire logic [7:0]  prio_low_reg_b_i,
   input  wire logic [7:0]  prio_high_reg_b_i,
   input  wire logic [1:0]  ext_trigger_type_i,
   // request sources
   input  wire logic [1:0]  ext_request_pin_i,
   input  wire logic        timer0_overflow_flag_i,
   input  wire logic        timer1_overflow_flag_i,
   input  wire logic        serial_tx_flag_i,
   input  wire logic        serial_rx_flag_i,
   input  wire logic        brownout_flag_i,
   input  wire logic        bus_attention_flag_i,
   input  wire logic        keypad_flag_i,
   input  wire logic        comparator_a_flag_i,
   input  wire logic        comparator_b_flag_i,
   input  wire logic        watchdog_overflow_flag_i,
   input  wire logic        bus_timeout_i,
   // core handshake
   input  wire logic        core_ack_i,
   input  wire logic        core_reti_i,
   input  wire logic        core_sleep_i,
   input  wire logic        core_pdown_i,
   output logic             irq_req_o,
   output logic [15:0]      irq_vector_o,
   output logic [1:0]       irq_level_o,
   output logic             wake_o,
   output logic [1:0]       ext_request_flag_o
);

   ////////////////////////////////////////////////////////////////////
   // machine cycle timebase

   logic [2:0] mc_cnt_q, mc_cnt_d;
   logic       mc_tick;

   // tick on the last count of each six-clock machine cycle
   always_comb begin
      mc_tick  = (mc_cnt_q == pic_pkg::MC_LAST);
      mc_cnt_d = mc_tick ? 3'h0 : mc_cnt_q + 3'h1;
   end

   // counter restarts with reset, so ticks align to the release
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         mc_cnt_q <= 3'h0;
      end else if (ce_i) begin
         mc_cnt_q <= mc_cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // external inputs

   logic [1:0] ext_flag;
   logic [1:0] ext_taken;
   logic       ack_q, ack_d;
   logic [3:0] ack_idx_q, ack_idx_d;

   // hardware clear happens on the vectoring acknowledge
   always_comb begin
      ext_taken[0] = ack_q && (ack_idx_q == pic_pkg::SRC_EXT0);   // [R13]
      ext_taken[1] = ack_q && (ack_idx_q == pic_pkg::SRC_EXT1);   // [R13]
   end

   // arbiter reads the flags directly; the exported copy lags a cycle
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_ext
         pic_ext_irq u_ext (
            .clk_i       (clk_i),
            .resetn_i    (resetn_i),
            .ce_i        (ce_i),
            .mc_tick_i   (mc_tick),
            .pin_i       (ext_request_pin_i[g]),
            .trig_edge_i (ext_trigger_type_i[g]),
            .taken_i     (ext_taken[g]),
            .flag_o      (ext_flag[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // source gather in arbitration order

   pic_pkg::pic_cfg_s cfg;
   pic_pkg::pic_src_t raw, en;
   logic [1:0]        lvl [pic_pkg::NSRC];
   logic [15:0]       vec [pic_pkg::NSRC];

   assign cfg = '{en_a: irq_enable_reg_a_i, en_b: irq_enable_reg_b_i,
                  pl_a: prio_low_reg_a_i,   ph_a: prio_high_reg_a_i,
                  pl_b: prio_low_reg_b_i,   ph_b: prio_high_reg_b_i};

   // index order is the tie-break ranking
   always_comb begin
      raw = {bus_timeout_i,                                 // 11 [R2]
             serial_tx_flag_i | serial_rx_flag_i,           // 10
             comparator_b_flag_i,                           // 9
             timer1_overflow_flag_i,                        // 8
             comparator_a_flag_i,                           // 7
             keypad_flag_i,                                 // 6
             ext_flag[1],                                   // 5
             bus_attention_flag_i,                          // 4 [R19]
             timer0_overflow_flag_i,                        // 3
             watchdog_overflow_flag_i,                      // 2
             brownout_flag_i,                               // 1
             ext_flag[0]};                                  // 0 [R6]
      en  = {cfg.en_b[pic_pkg::EB_BTMR],  cfg.en_a[pic_pkg::EA_SER],
             cfg.en_b[pic_pkg::EB_CMPB],  cfg.en_a[pic_pkg::EA_TMR1],
             cfg.en_b[pic_pkg::EB_CMPA],  cfg.en_b[pic_pkg::EB_KEYP],
             cfg.en_a[pic_pkg::EA_EXT1],  cfg.en_b[pic_pkg::EB_TWB],
             cfg.en_a[pic_pkg::EA_TMR0],  cfg.en_a[pic_pkg::EA_WDOG],
             cfg.en_a[pic_pkg::EA_BROWN], cfg.en_a[pic_pkg::EA_EXT0]};
      // level = {high bit, low bit}                         [R1] [R18]
      lvl[0]  = {cfg.ph_a[pic_pkg::EA_EXT0],  cfg.pl_a[pic_pkg::EA_EXT0]};
      lvl[1]  = {cfg.ph_a[pic_pkg::EA_BROWN], cfg.pl_a[pic_pkg::EA_BROWN]};
      lvl[2]  = {cfg.ph_a[pic_pkg::EA_WDOG],  cfg.pl_a[pic_pkg::EA_WDOG]};
      lvl[3]  = {cfg.ph_a[pic_pkg::EA_TMR0],  cfg.pl_a[pic_pkg::EA_TMR0]};
      lvl[4]  = {cfg.ph_b[pic_pkg::EB_TWB],   cfg.pl_b[pic_pkg::EB_TWB]};
      lvl[5]  = {cfg.ph_a[pic_pkg::EA_EXT1],  cfg.pl_a[pic_pkg::EA_EXT1]};
      lvl[6]  = {cfg.ph_b[pic_pkg::EB_KEYP],  cfg.pl_b[pic_pkg::EB_KEYP]};
      lvl[7]  = {cfg.ph_b[pic_pkg::EB_CMPA],  cfg.pl_b[pic_pkg::EB_CMPA]};
      lvl[8]  = {cfg.ph_a[pic_pkg::EA_TMR1],  cfg.pl_a[pic_pkg::EA_TMR1]};
      lvl[9]  = {cfg.ph_b[pic_pkg::EB_CMPB],  cfg.pl_b[pic_pkg::EB_CMPB]};
      lvl[10] = {cfg.ph_a[pic_pkg::EA_SER],   cfg.pl_a[pic_pkg::EA_SER]};
      lvl[11] = {cfg.ph_b[pic_pkg::EB_BTMR],  cfg.pl_b[pic_pkg::EB_BTMR]};
      // fixed vectors                                       [R7]
      vec[0]  = pic_pkg::VEC_EXT0;
      vec[1]  = pic_pkg::VEC_BROWN;
      vec[2]  = pic_pkg::VEC_WDOG;
      vec[3]  = pic_pkg::VEC_TMR0;
      vec[4]  = pic_pkg::VEC_TWB;
      vec[5]  = pic_pkg::VEC_EXT1;
      vec[6]  = pic_pkg::VEC_KEYP;
      vec[7]  = pic_pkg::VEC_CMPA;
      vec[8]  = pic_pkg::VEC_TMR1;
      vec[9]  = pic_pkg::VEC_CMPB;
      vec[10] = pic_pkg::VEC_SER;
      vec[11] = pic_pkg::VEC_BTMR;
   end

   ////////////////////////////////////////////////////////////////////
   // arbitration

   pic_pkg::pic_src_t act;
   pic_pkg::pic_req_s win;

   // global bit gates every source regardless of own enable
   assign act = raw & en & {pic_pkg::NSRC{cfg.en_a[pic_pkg::EA_GLOB]}};
                                                            // [R3] [R2]

   // scan from last rank down so lower index wins ties; an equal or
   // higher level replaces the current pick
   always_comb begin
      win = '0;
      for (int i = pic_pkg::NSRC - 1; i >= 0; i--) begin
         if (act[i] && (!win.valid || lvl[i] >= win.lvl)) begin
            win.valid = 1'b1;                               // [R5] [R6]
            win.idx   = i[3:0];
            win.lvl   = lvl[i];
            win.vec   = vec[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // in-service stack, one bit per level

   logic [3:0] isr_q, isr_d;
   logic       preempt_ok;
   logic [3:0] top_lvl_mask;

   // highest active level sets the bar; nothing above 11 exists, so a
   // top-level routine is never interrupted
   always_comb begin
      top_lvl_mask = 4'h0;
      for (int l = 0; l < 4; l++) begin
         // shift keeps the slice width fixed for any loop index
         top_lvl_mask[l] = |(isr_q >> l);
      end
      preempt_ok = win.valid && !top_lvl_mask[win.lvl];     // [R4]
   end

   ////////////////////////////////////////////////////////////////////
   // request handshake with the core

   pic_pkg::pic_state_e st_q, st_d;
   logic        req_q, req_d;
   logic [15:0] vec_q, vec_d;
   logic [1:0]  lvlo_q, lvlo_d;
   logic        wake_q, wake_d;
   // source index rides with the presented vector, so the hardware
   // clear on acknowledge hits the source the core actually took
   logic [3:0]  idx_q, idx_d;

   always_comb begin
      st_d      = st_q;
      req_d     = req_q;
      vec_d     = vec_q;
      lvlo_d    = lvlo_q;
      ack_d     = 1'b0;
      ack_idx_d = ack_idx_q;
      idx_d     = idx_q;
      isr_d     = isr_q;
      wake_d    = 1'b0;
      // return pops the highest active level, exposing waiting level
      // requests again on the next cycle
      if (core_reti_i) begin
         for (int l = 0; l < 4; l++) begin
            // only the topmost set level has nothing set above it
            if (isr_q[l] && !(|(isr_q >> (l + 1)))) begin
               isr_d[l] = 1'b0;                             // [R15]
            end
         end
      end
      case (st_q)
         pic_pkg::PIC_RUN: begin
            req_d  = preempt_ok;
            vec_d  = win.vec;
            lvlo_d = win.lvl;
            idx_d  = win.idx;
            if (req_q && core_ack_i) begin
               req_d          = 1'b0;
               ack_d          = 1'b1;
               ack_idx_d      = idx_q;                      // [R13]
               isr_d[lvlo_q]  = 1'b1;
               st_d           = pic_pkg::PIC_ACK;
            end else if (core_sleep_i) begin
               st_d = pic_pkg::PIC_SLEEP;
            end
         end
         pic_pkg::PIC_ACK: begin
            // one settle cycle lets the edge flag clear first  [R13]
            st_d = pic_pkg::PIC_RUN;
         end
         pic_pkg::PIC_SLEEP: begin
            // nothing is presented to a sleeping core
            req_d = 1'b0;
            // power down: only wake capable sources count
            if ((core_pdown_i && |(act & pic_pkg::WAKE_MASK)) ||
                (!core_pdown_i && |act)) begin
               wake_d = 1'b1;                               // [R8] [R17]
               st_d   = pic_pkg::PIC_RUN;
            end else if (!core_sleep_i) begin
               // core left sleep on its own: resume arbitration
               st_d = pic_pkg::PIC_RUN;
            end
         end
         default: st_d = pic_pkg::PIC_RUN;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         st_q      <= pic_pkg::PIC_RUN;
         req_q     <= 1'b0;
         vec_q     <= 16'h0000;
         lvlo_q    <= 2'h0;
         ack_q     <= 1'b0;
         ack_idx_q <= 4'h0;
         isr_q     <= 4'h0;
         wake_q    <= 1'b0;
         idx_q     <= 4'h0;
      end else if (ce_i) begin
         st_q      <= st_d;
         req_q     <= req_d;
         vec_q     <= vec_d;
         lvlo_q    <= lvlo_d;
         ack_q     <= ack_d;
         ack_idx_q <= ack_idx_d;
         isr_q     <= isr_d;
         wake_q    <= wake_d;
         idx_q     <= idx_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs, all from flops

   // exported flags trail the internal ones by a cycle, for flop outputs
   logic [1:0] extf_q;

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         extf_q <= 2'h0;
      end else if (ce_i) begin
         extf_q <= ext_flag;
      end
   end

   assign irq_req_o          = req_q;
   assign irq_vector_o       = vec_q;
   assign irq_level_o        = lvlo_q;
   assign wake_o             = wake_q;
   assign ext_request_flag_o = extf_q;

endmodule

//--- rtl/pic_pkg.sv
// Function
// R1: four priority levels; each source picks one via its own bit pair.
// R2: twelve sources, each with an individual enable bit.
// R3: cleared global enable blocks every source at once.
// R4: only a strictly higher level preempts; top level is never preempted.
// R5: simultaneous requests at different levels: higher level served first.
// R6: equal-level ties by fixed ranking, external 0 first, bus timer last.
// R7: fixed vector address per source, 0003h through 0073h.
// R8: power-down wake: externals, brownout, keypad, comparators, watchdog.
// R9: trigger-type bit 0 gives low-level trigger, 1 gives edge trigger.
// R10: edge mode sets flag on sample high followed by next sample low.
// R11: pins sampled once per machine cycle; source holds levels six clocks.
// R12: edge source holds high one machine cycle, then low one.
// R13: edge flag cleared by hardware when core vectors to its routine.
// R14: level source holds request until the interrupt is taken.
// R15: level pin still low after routine ends raises another interrupt.
// R16: level-mode flag follows sampled pin, needs no software clear.
// R17: enabled external request wakes core from idle or power down.
// R18: priority level is {high bit, low bit}; 11 highest, 00 lowest.
// R19: two-wire bus request comes from the bus attention flag.
package pic_pkg;

   localparam int unsigned NSRC     = 12;
   localparam int unsigned LVL_W    = 2;
   localparam int unsigned IDX_W    = 4;
   localparam int unsigned VEC_W    = 16;

   // source index, in arbitration order: index 0 ranks first
   localparam logic [3:0] SRC_EXT0  = 4'h0;
   localparam logic [3:0] SRC_BROWN = 4'h1;
   localparam logic [3:0] SRC_WDOG  = 4'h2;
   localparam logic [3:0] SRC_TMR0  = 4'h3;
   localparam logic [3:0] SRC_TWB   = 4'h4;
   localparam logic [3:0] SRC_EXT1  = 4'h5;
   localparam logic [3:0] SRC_KEYP  = 4'h6;
   localparam logic [3:0] SRC_CMPA  = 4'h7;
   localparam logic [3:0] SRC_TMR1  = 4'h8;
   localparam logic [3:0] SRC_CMPB  = 4'h9;
   localparam logic [3:0] SRC_SER   = 4'ha;
   localparam logic [3:0] SRC_BTMR  = 4'hb;

   // enable register a bit positions
   localparam int unsigned EA_EXT0  = 0;
   localparam int unsigned EA_TMR0  = 1;
   localparam int unsigned EA_EXT1  = 2;
   localparam int unsigned EA_TMR1  = 3;
   localparam int unsigned EA_SER   = 4;
   localparam int unsigned EA_BROWN = 5;
   localparam int unsigned EA_WDOG  = 6;
   localparam int unsigned EA_GLOB  = 7;
   // enable register b bit positions
   localparam int unsigned EB_TWB   = 0;
   localparam int unsigned EB_KEYP  = 1;
   localparam int unsigned EB_CMPB  = 2;
   localparam int unsigned EB_CMPA  = 5;
   localparam int unsigned EB_BTMR  = 7;

   // vector table, listed in address order
   localparam logic [15:0] VEC_EXT0  = 16'h0003;
   localparam logic [15:0] VEC_TMR0  = 16'h000b;
   localparam logic [15:0] VEC_EXT1  = 16'h0013;
   localparam logic [15:0] VEC_TMR1  = 16'h001b;
   localparam logic [15:0] VEC_SER   = 16'h0023;
   localparam logic [15:0] VEC_BROWN = 16'h002b;
   localparam logic [15:0] VEC_TWB   = 16'h0033;
   localparam logic [15:0] VEC_KEYP  = 16'h003b;
   localparam logic [15:0] VEC_CMPB  = 16'h0043;
   localparam logic [15:0] VEC_WDOG  = 16'h0053;
   localparam logic [15:0] VEC_CMPA  = 16'h0063;
   localparam logic [15:0] VEC_BTMR  = 16'h0073;

   // wake capable sources, bit per arbitration index
   localparam logic [11:0] WAKE_MASK = 12'h2e7;

   // machine cycle is six core clocks
   localparam int unsigned MC_CLKS  = 6;
   localparam logic [2:0]  MC_LAST  = 3'h5;
   localparam logic [7:0]  REG_RST  = 8'h00;

   typedef logic [11:0] pic_src_t;

   typedef struct packed {
      logic [7:0] en_a;
      logic [7:0] en_b;
      logic [7:0] pl_a;
      logic [7:0] ph_a;
      logic [7:0] pl_b;
      logic [7:0] ph_b;
   } pic_cfg_s;

   typedef struct packed {
      logic        valid;
      logic [3:0]  idx;
      logic [1:0]  lvl;
      logic [15:0] vec;
   } pic_req_s;

   typedef enum logic [1:0] {
      PIC_RUN   = 2'b00,
      PIC_ACK   = 2'b01,
      PIC_SLEEP = 2'b11
   } pic_state_e;

endpackage

//--- rtl/pic_ext_irq.sv
`timescale 1ns/1ps
// one external request input: sampler, trigger logic and flag
module pic_ext_irq (
   input  wire logic clk_i,
   input  wire logic resetn_i,
   input  wire logic ce_i,
   input  wire logic mc_tick_i,
   input  wire logic pin_i,
   input  wire logic trig_edge_i,
   input  wire logic taken_i,
   output logic      flag_o
);

   logic samp_q, samp_d;
   logic flag_q, flag_d;

   // sample once per machine cycle; edge flag set beats hardware clear
   always_comb begin
      samp_d = samp_q;
      flag_d = flag_q;
      if (mc_tick_i) begin
         samp_d = pin_i;                               // [R11]
      end
      if (!trig_edge_i) begin
         flag_d = ~samp_q;                             // [R9] [R16] [R15]
      end else begin
         if (taken_i) begin
            flag_d = 1'b0;                             // [R13]
         end
         if (mc_tick_i && samp_q && !pin_i) begin
            flag_d = 1'b1;                             // [R10]
         end
      end
   end

   // samp resets high: idle pin, no spurious level request
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         samp_q <= 1'b1;
         flag_q <= 1'b0;
      end else if (ce_i) begin
         samp_q <= samp_d;
         flag_q <= flag_d;
      end
   end

   assign flag_o = flag_q;

endmodule

//--- bench/pic_properties.sv
`timescale 1ns/1ps
// watches the controller pins; top-level service is tracked in helper logic
module pic_chk (
   input wire logic        clk_i,
   input wire logic        resetn_i,
   input wire logic [7:0]  irq_enable_reg_a_i,
   input wire logic [1:0]  ext_request_pin_i,
   input wire logic        brownout_flag_i,
   input wire logic        keypad_flag_i,
   input wire logic        comparator_a_flag_i,
   input wire logic        comparator_b_flag_i,
   input wire logic        watchdog_overflow_flag_i,
   input wire logic        core_ack_i,
   input wire logic        core_reti_i,
   input wire logic        core_sleep_i,
   input wire logic        core_pdown_i,
   input wire logic        irq_req_o,
   input wire logic [15:0] irq_vector_o,
   input wire logic [1:0]  irq_level_o,
   input wire logic        wake_o,
   input wire logic [1:0]  ext_request_flag_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   logic top_busy_q;
   logic top_busy_d;
   logic wake_src;

   ////////////////////////////////////////////////////////////////////////
   // a top-level routine stays in service until its return
   always_comb begin
      top_busy_d = top_busy_q;
      if (irq_req_o && core_ack_i && irq_level_o == 2'b11) begin
         top_busy_d = 1'b1;
      end else if (core_reti_i) begin
         top_busy_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         top_busy_q <= 1'b0;
      end else begin
         top_busy_q <= top_busy_d;
      end
   end

   // wake-capable flags; externals are judged by their pins
   assign wake_src = brownout_flag_i | keypad_flag_i | comparator_a_flag_i
                   | comparator_b_flag_i | watchdog_overflow_flag_i;

   ////////////////////////////////////////////////////////////////////////
   sequence s_take;
      irq_req_o && core_ack_i;
   endsequence
   sequence s_settle;
      !irq_req_o [*2];
   endsequence

   AST_ACK_DROP: assert property (s_take |=> s_settle)
      else $error("request not dropped after ack");
   AST_REQ_HOLD: assert property (
      irq_req_o && !core_ack_i && !core_sleep_i |=> irq_req_o)
      else $error("request withdrawn without ack");
   AST_GLOBAL_OFF: assert property (
      $rose(irq_req_o) |-> $past(irq_enable_reg_a_i[7]))
      else $error("request raised with global enable clear");
   AST_VEC_LEGAL: assert property ($past(irq_req_o) && irq_req_o |->
      irq_vector_o inside {16'h0003, 16'h000b, 16'h0013, 16'h001b,
      16'h0023, 16'h002b, 16'h0033, 16'h003b, 16'h0043, 16'h0053,
      16'h0063, 16'h0073})
      else $error("vector outside the table");
   AST_TOP_HOLD: assert property (top_busy_q |=> !irq_req_o)
      else $error("top level routine preempted");
   AST_WAKE_PULSE: assert property (wake_o |=> !wake_o)
      else $error("wake longer than one cycle");
   AST_WAKE_CAUSE: assert property (wake_o |-> $past(core_sleep_i, 2))
      else $error("wake while core was running");
   AST_PDOWN_MASK: assert property (wake_o |-> !($past(core_pdown_i) &&
      !$past(wake_src) && $past(ext_request_pin_i) == 2'b11 &&
      $past(ext_request_flag_o) == 2'b00))
      else $error("power down left by a source without wake");
endmodule

bind pic_top pic_chk i_chk (
   .clk_i, .resetn_i, .irq_enable_reg_a_i, .ext_request_pin_i,
   .brownout_flag_i, .keypad_flag_i, .comparator_a_flag_i,
   .comparator_b_flag_i, .watchdog_overflow_flag_i, .core_ack_i,
   .core_reti_i, .core_sleep_i, .core_pdown_i, .irq_req_o, .irq_vector_o,
   .irq_level_o, .wake_o, .ext_request_flag_o
);

//--- bench/pic_src_model.sv
`timescale 1ns/1ps
// two external request sources; pins idle high on their pull-ups
module pic_src_model (
   input  wire logic       clk_i,
   input  wire logic [1:0] req_i,
   output logic [1:0]      pin_o
);
   logic [3:0] hold_q [2];

   initial begin
      pin_o = 2'b11;
      hold_q[0] = 4'h0;
      hold_q[1] = 4'h0;
   end

   // every level stands at least thirteen clocks, so a slow request still gets sampled
   always @(posedge clk_i) begin
      for (int k = 0; k < 2; k++) begin
         if (hold_q[k] != 4'h0) begin
            hold_q[k] <= hold_q[k] - 4'h1;
         end else if (req_i[k] == pin_o[k]) begin
            pin_o[k] <= ~pin_o[k]; // low while the request stands
            hold_q[k] <= 4'hc;
         end
      end
   end
endmodule

//--- bench/test_prioritized_interrupt_controller.sv
`timescale 1ns/1ps
module test_prioritized_interrupt_controller;
   logic        clk_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic [11:0] src = '0;
   logic [11:0] enm = '1;
   logic [11:0] pend = '0;
   logic        glob = 1'b1;
   logic [1:0]  trig = 2'b00;
   logic        rx_sel = 1'b0;
   logic        ack = 1'b0;
   logic        reti = 1'b0;
   logic        sleep = 1'b0;
   logic        pdown = 1'b0;
   logic [1:0]  lvl [12];
   logic [15:0] en, pl, ph;
   logic [1:0]  pin, lvl_o, flag_o;
   logic        req_o, wake;
   logic [15:0] vec_o;
   int          failures = 0;
   int          num_checks = 0;
   logic [7:0]  rnd = 8'h61;
   int          isq [$];
   int          pos [12] = '{0, 5, 6, 1, 8, 2, 9, 13, 3, 10, 4, 15};
   logic [15:0] vt [12] = '{16'h0003, 16'h002b, 16'h0053, 16'h000b,
      16'h0033, 16'h0013, 16'h003b, 16'h0063, 16'h001b, 16'h0043,
      16'h0023, 16'h0073};
   bit          wk [12] = '{1, 1, 1, 0, 0, 1, 1, 1, 0, 1, 0, 0};

   always #2 clk_i = ~clk_i;

   // fold per-source enables and levels into the register images
   always_comb begin
      en = '0;
      pl = '0;
      ph = '0;
      for (int i = 0; i < 12; i++) begin
         en[pos[i]] = enm[i];
         pl[pos[i]] = lvl[i][0];
         ph[pos[i]] = lvl[i][1];
      end
      en[7] = glob;
   end

   pic_src_model i_src (.clk_i(clk_i), .req_i({src[5], src[0]}), .pin_o(pin));

   pic_top i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1),
      .irq_enable_reg_a_i(en[7:0]), .irq_enable_reg_b_i(en[15:8]),
      .prio_low_reg_a_i(pl[7:0]), .prio_high_reg_a_i(ph[7:0]),
      .prio_low_reg_b_i(pl[15:8]), .prio_high_reg_b_i(ph[15:8]),
      .ext_trigger_type_i(trig), .ext_request_pin_i(pin),
      .timer0_overflow_flag_i(src[3]), .timer1_overflow_flag_i(src[8]),
      .serial_tx_flag_i(src[10] & !rx_sel),
      .serial_rx_flag_i(src[10] & rx_sel), .brownout_flag_i(src[1]),
      .bus_attention_flag_i(src[4]), .keypad_flag_i(src[6]),
      .comparator_a_flag_i(src[7]), .comparator_b_flag_i(src[9]),
      .watchdog_overflow_flag_i(src[2]), .bus_timeout_i(src[11]),
      .core_ack_i(ack), .core_reti_i(reti), .core_sleep_i(sleep),
      .core_pdown_i(pdown), .irq_req_o(req_o), .irq_vector_o(vec_o),
      .irq_level_o(lvl_o), .wake_o(wake), .ext_request_flag_o(flag_o));

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] lfsr(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction

   task automatic cmp(input bit ok, input string msg);
      num_checks++;
      if (!ok) begin
         failures++;
         $display("mismatch %0t %s", $time, msg);
      end
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // reference: highest level above every in-service level, then rank
   function automatic int winner();
      int best;
      int top;
      best = -1;
      top = (isq.size() > 0) ? isq[$] : -1;
      for (int i = 0; i < 12; i++) begin
         if (glob && enm[i] && (src[i] || pend[i]) && int'(lvl[i]) > top
             && (best < 0 || lvl[i] > lvl[best])) begin
            best = i;
         end
      end
      return best;
   endfunction

   task automatic check(output int w);
      wait_clk(12);
      w = winner();
      cmp(req_o === (w >= 0), "request line");
      if (w >= 0) begin
         cmp(vec_o === vt[w], "vector");
         cmp(lvl_o === lvl[w], "level");
      end
   endtask

   task automatic take(output int w);
      check(w);
      if (w >= 0) begin
         ack <= 1'b1;
         @(posedge clk_i);
         ack <= 1'b0;
         isq.push_back(lvl[w]);
         pend[w] <= 1'b0; // vectoring clears the edge flag
      end
   endtask

   task automatic ret();
      wait_clk(24);
      reti <= 1'b1;
      @(posedge clk_i);
      reti <= 1'b0;
      void'(isq.pop_back());
   endtask

   task automatic do_reset();
      // sources drop first, while sleep still excuses a withdrawn request
      src <= '0;
      wait_clk(16);
      sleep <= 1'b0;
      pdown <= 1'b0;
      resetn_i <= 1'b0;
      wait_clk(8);
      resetn_i <= 1'b1;
      isq.delete();
   endtask

   task automatic wrap_up();
      if (failures == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      int w;
      int n;
      int k;
      for (int i = 0; i < 12; i++) lvl[i] = 2'b00;
      wait_clk(8);
      resetn_i <= 1'b1;
      // each source alone at a random level, first with its enable off
      for (int i = 0; i < 12; i++) begin
         rnd = lfsr(rnd);
         lvl[i] <= rnd[1:0];
         rx_sel <= rnd[2];
         src[i] <= 1'b1;
         enm[i] <= 1'b0;
         check(w);
         enm[i] <= 1'b1;
         take(w);
         src[i] <= 1'b0;
         ret();
      end
      // all twelve at one level are served strictly by rank
      rnd = lfsr(rnd);
      for (int i = 0; i < 12; i++) lvl[i] <= rnd[1:0];
      src <= '1;
      for (int i = 0; i < 12; i++) begin
         take(w);
         src[i] <= 1'b0;
         check(w);
         ret();
      end
      // mixed levels, top level held, preemption only from above
      lvl[8] <= 2'd1;
      lvl[11] <= 2'd3;
      lvl[10] <= 2'd0;
      lvl[7] <= 2'd1;
      lvl[2] <= 2'd2;
      src <= 12'hd00;
      take(w);
      check(w);
      src[11] <= 1'b0;
      ret();
      take(w);
      src[8] <= 1'b0;
      src[7] <= 1'b1;
      check(w);
      src[2] <= 1'b1;
      take(w);
      src <= '0;
      ret();
      ret();
      check(w);
      // global enable off holds every source back
      glob <= 1'b0;
      src <= 12'h0f0;
      check(w);
      glob <= 1'b1;
      take(w);
      src <= '0;
      ret();
      // level-mode pin: flag tracks it, re-raised while still held
      src[0] <= 1'b1;
      check(w);
      cmp(flag_o === 2'b01, "level flag");
      take(w);
      ret();
      take(w);
      src[0] <= 1'b0;
      ret();
      check(w);
      cmp(flag_o === 2'b00, "level flag clear");
      // edge mode: one falling edge latches until vectored
      trig <= 2'b10;
      src[5] <= 1'b1;
      pend[5] <= 1'b1;
      @(posedge clk_i);
      src[5] <= 1'b0;
      check(w);
      cmp(flag_o === 2'b10, "edge flag");
      take(w);
      wait_clk(4);
      cmp(flag_o === 2'b00, "edge flag clear");
      ret();
      check(w);
      trig <= 2'b00;
      // power down per source, then idle with a timer
      for (int m = 0; m < 13; m++) begin
         k = (m < 12) ? m : 3;
         do_reset();
         sleep <= 1'b1;
         pdown <= (m < 12);
         wait_clk(3);
         src[k] <= 1'b1;
         n = 0;
         while (n < 40 && wake !== 1'b1) begin
            @(negedge clk_i);
            n++;
         end
         @(posedge clk_i);
         cmp((n < 40) == ((m < 12) ? wk[k] : 1'b1), "wake");
      end
      do_reset();
      wrap_up();
   end
endmodule
